//--- logic/p5fs_top.sv
/*
  Port 5 pin function select: APB register that switches pins 6..2 between general I/O,
  an NMOS open-drain output (pin 6) and wakeup / external ADC trigger inputs (pins 5..2).
  Assumes the port data and direction logic, the wakeup controller and the ADC trigger
  logic share clk; pad inputs are asynchronous and are synchronised here.
*/
// Chosen here: the address map and the APB interface to the registers.
// Operation
// - Bit 6 at 0 makes pin 6 general I/O, at 1 makes it an NMOS open-drain output.
// - Bit 5 at 0 makes pin 5 general I/O, at 1 makes it the wakeup and external ADC trigger input.
// - Bit 4 at 0 makes pin 4 general I/O, at 1 makes it a wakeup interrupt input.
// - Bit 3 at 0 makes pin 3 general I/O, at 1 makes it a wakeup interrupt input.
// - Bit 2 at 0 makes pin 2 general I/O, at 1 makes it a wakeup interrupt input.
// - Select bits 6 to 2 reset to 0 (general I/O) and are read and written by software.
`timescale 1ns/10ps
`default_nettype none
module p5fs_top
  import p5fs_pkg::*;
(
  input wire logic clk, // System clock, 10 MHz
  input wire logic rst_n, // Asynchronous reset, active low
  input wire p5fs_apb_req_t apbReq, // APB request from the bus master
  output p5fs_apb_rsp_t apbRsp, // APB answer, registered
  input wire p5fs_pin_drive_t gpioDrive, // Data and direction from the port logic
  input wire logic [PIN_HI:PIN_LO] padIn, // Pad input levels, asynchronous
  output p5fs_pin_drive_t padDrive, // Pad output level and enable
  output logic [PIN_HI:PIN_LO] gpioIn, // Synchronised pad levels to the port logic
  output logic [5:2] wakeupIn_n, // Wakeup inputs to the wakeup controller
  output logic adcExternalTriggerIn_n // External trigger to the ADC
);
  logic [SEL_W-1:0] port5FunctionSelect;
  logic [PIN_HI:PIN_LO] padSync;

  p5fs_sync uSync (
    .clk(clk),
    .rst_n(rst_n),
    .padIn(padIn),
    .syncOut(padSync)
  );

  // APB decode
  wire setupPhase = apbReq.psel && !apbReq.penable;
  wire accessDone = apbReq.psel && apbReq.penable && apbRsp.pready;
  wire hitSelect = (apbReq.paddr == OFS_FUNCTION_SELECT);
  wire hitLevel = (apbReq.paddr == OFS_PIN_LEVEL);
  wire hitAny = hitSelect || hitLevel;
  // The level word is read-only; a write to it is refused like an unmapped one
  wire badAccess = !hitAny || (apbReq.pwrite && hitLevel);
  wire writeSelect = accessDone && apbReq.pwrite && hitSelect;

  wire [SEL_W-1:0] next_port5FunctionSelect =
    (apbReq.pwdata[SEL_W-1:0] & SEL_WRITE_MASK) | (port5FunctionSelect & ~SEL_WRITE_MASK);

  wire [APB_DATA_W-1:0] readValue =
    hitSelect ? {{(APB_DATA_W-SEL_W){1'b0}}, port5FunctionSelect} :
    hitLevel ? {{(APB_DATA_W-PIN_HI-1){1'b0}}, padSync, {PIN_LO{1'b0}}} :
    RDATA_RESET;

  // One wait-free answer: pready rises in the first access cycle
  wire next_pready = setupPhase;
  wire next_pslverr = setupPhase && badAccess;
  wire [APB_DATA_W-1:0] next_prdata = (setupPhase && !apbReq.pwrite && !badAccess) ? readValue : RDATA_RESET;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      apbRsp.pready <= 1'b0;
      apbRsp.pslverr <= 1'b0;
      apbRsp.prdata <= RDATA_RESET;
    end else begin
      apbRsp.pready <= next_pready;
      apbRsp.pslverr <= next_pslverr;
      apbRsp.prdata <= next_prdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      port5FunctionSelect <= SEL_RESET;
    end else if (writeSelect) begin
      port5FunctionSelect <= next_port5FunctionSelect;
    end
  end

  // Pin function selection
  wire pin6OpenDrainSelect = port5FunctionSelect[BIT_PIN6_OPEN_DRAIN];
  wire [5:2] wakeupSelect = {
    port5FunctionSelect[BIT_PIN5_WAKEUP],
    port5FunctionSelect[BIT_PIN4_WAKEUP],
    port5FunctionSelect[BIT_PIN3_WAKEUP],
    port5FunctionSelect[BIT_PIN2_WAKEUP]
  };

  // Nets, not variables: each bit is driven by its own continuous assignment
  wire p5fs_pin_drive_t next_padDrive;
  wire [5:2] next_wakeupIn_n;

  genvar pinIdx;
  generate
    for (pinIdx = 2; pinIdx <= 5; pinIdx++) begin : gWakeupPin
      // A wakeup pin is input only; its output driver is released
      assign next_padDrive.level[pinIdx] = wakeupSelect[pinIdx] ? 1'b0 : gpioDrive.level[pinIdx];
      assign next_padDrive.enable[pinIdx] = wakeupSelect[pinIdx] ? 1'b0 : gpioDrive.enable[pinIdx];
      // Idle high when not selected, so general I/O traffic never wakes the chip
      assign next_wakeupIn_n[pinIdx] = wakeupSelect[pinIdx] ? padSync[pinIdx] : WAKEUP_IDLE;
    end
  endgenerate

  // Open drain only pulls low: the pad is driven while the port outputs a 0
  assign next_padDrive.level[PIN_HI] = pin6OpenDrainSelect ? 1'b0 : gpioDrive.level[PIN_HI];
  assign next_padDrive.enable[PIN_HI] = pin6OpenDrainSelect ?
    (gpioDrive.enable[PIN_HI] && !gpioDrive.level[PIN_HI]) : gpioDrive.enable[PIN_HI];

  wire next_adcExternalTriggerIn_n = wakeupSelect[5] ? padSync[5] : WAKEUP_IDLE;

  // Registered outputs cost one cycle of latency but keep pad enables glitch free
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      padDrive <= '0;
      gpioIn <= '1;
      wakeupIn_n <= '1;
      adcExternalTriggerIn_n <= WAKEUP_IDLE;
    end else begin
      padDrive <= next_padDrive;
      gpioIn <= padSync;
      wakeupIn_n <= next_wakeupIn_n;
      adcExternalTriggerIn_n <= next_adcExternalTriggerIn_n;
    end
  end
endmodule
`default_nettype wire

//--- logic/p5fs_pkg.sv
/*
  Shared constants and carrier types for the port 5 pin function select block.
  Assumes a 32-bit APB slave interface and the system clock at 10 MHz.
*/
`default_nettype none
package p5fs_pkg;
  localparam int unsigned APB_ADDR_W = 12;
  localparam int unsigned APB_DATA_W = 32;
  localparam int unsigned SEL_W = 8;
  localparam int unsigned PIN_LO = 2;
  localparam int unsigned PIN_HI = 6;

  // Byte addresses of the register words
  localparam logic [11:0] OFS_FUNCTION_SELECT = 12'h000;
  localparam logic [11:0] OFS_PIN_LEVEL = 12'h004;

  // Field positions inside the function select register
  localparam int unsigned BIT_PIN6_OPEN_DRAIN = 6;
  localparam int unsigned BIT_PIN5_WAKEUP = 5;
  localparam int unsigned BIT_PIN4_WAKEUP = 4;
  localparam int unsigned BIT_PIN3_WAKEUP = 3;
  localparam int unsigned BIT_PIN2_WAKEUP = 2;

  // Writable bits are 6..2; bit 7 and bits 1..0 stay zero here
  localparam logic [7:0] SEL_WRITE_MASK = 8'h7C;
  localparam logic [7:0] SEL_RESET = 8'h00;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // Level presented on an active-low wakeup or trigger line while not selected
  localparam logic WAKEUP_IDLE = 1'b1;

  localparam int unsigned SYNC_STAGES = 2;

  // Drive of the five shared pins, index = port 5 bit number
  typedef struct packed {
    logic [PIN_HI:PIN_LO] level;
    logic [PIN_HI:PIN_LO] enable;
  } p5fs_pin_drive_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [APB_DATA_W-1:0] pwdata;
  } p5fs_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [APB_DATA_W-1:0] prdata;
  } p5fs_apb_rsp_t;
endpackage
`default_nettype wire

//--- logic/p5fs_sync.sv
/*
  Two flip-flop synchroniser for the five port 5 pad inputs.
  Assumes the pad levels are asynchronous to clk; only the second stage is read outside.
*/
`timescale 1ns/10ps
`default_nettype none
module p5fs_sync
  import p5fs_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [PIN_HI:PIN_LO] padIn, // Raw pad levels
  output logic [PIN_HI:PIN_LO] syncOut // Levels after two stages
);
  logic [PIN_HI:PIN_LO] stage1;

  // Reset to high: idle level of the active-low wakeup lines, so no false event after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= '1;
      syncOut <= '1;
    end else begin
      stage1 <= padIn;
      syncOut <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- dv/p5fs_properties.sv
/* Checker for the port 5 function select block, bound to p5fs_top.
   Assumes one clock domain; a shadow of the select word follows completed APB writes. */
`timescale 1ns/10ps
`default_nettype none
module p5fs_properties
  import p5fs_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire p5fs_apb_req_t apbReq, // Request
  input wire p5fs_apb_rsp_t apbRsp, // Answer
  input wire p5fs_pin_drive_t gpioDrive, // Port drive
  input wire p5fs_pin_drive_t padDrive, // Pad drive
  input wire logic [5:2] wakeupIn_n, // Wakeup lines
  input wire logic adcExternalTriggerIn_n // Trigger line
);
  logic [6:2] shadow, modeQ, enQ, lvQ;
  wire wrSel = apbReq.psel & apbReq.penable & apbRsp.pready & apbReq.pwrite & (apbReq.paddr == OFS_FUNCTION_SELECT);
  // Expected pad drive one cycle on, from the select word and the port drive
  wire [6:2] expEn = (gpioDrive.enable & ~shadow) | ({shadow[6], 4'h0} & gpioDrive.enable & ~gpioDrive.level);
  wire [6:2] expLv = gpioDrive.level & ~shadow;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {shadow, modeQ, enQ, lvQ} <= '0;
    end else begin
      shadow <= wrSel ? apbReq.pwdata[6:2] : shadow;
      {modeQ, enQ, lvQ} <= {shadow, expEn, expLv};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_PREADY_AFTER_SETUP: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("No answer after setup");
  AST_PREADY_ONE: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("Ready longer than one cycle");
  AST_PIN6_DRIVE: assert property (padDrive.enable[6] == enQ[6] && padDrive.level[6] == lvQ[6])
    else $error("Pin 6 drive wrong");
  AST_PIN5_DRIVE: assert property (padDrive.enable[5] == enQ[5] && padDrive.level[5] == lvQ[5])
    else $error("Pin 5 drive wrong");
  AST_PIN4_DRIVE: assert property (padDrive.enable[4] == enQ[4] && padDrive.level[4] == lvQ[4])
    else $error("Pin 4 drive wrong");
  AST_PIN3_DRIVE: assert property (padDrive.enable[3] == enQ[3] && padDrive.level[3] == lvQ[3])
    else $error("Pin 3 drive wrong");
  AST_PIN2_DRIVE: assert property (padDrive.enable[2] == enQ[2] && padDrive.level[2] == lvQ[2])
    else $error("Pin 2 drive wrong");
  AST_TRIGGER_PAIR: assert property (adcExternalTriggerIn_n == wakeupIn_n[5])
    else $error("Trigger differs from pin 5 wakeup");
  AST_WAKE_IDLE: assert property ((wakeupIn_n | modeQ[5:2]) == 4'hF)
    else $error("Wakeup line active while not selected");
endmodule
bind p5fs_top p5fs_properties u_props (.clk(clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp),
  .gpioDrive(gpioDrive), .padDrive(padDrive), .wakeupIn_n(wakeupIn_n), .adcExternalTriggerIn_n(adcExternalTriggerIn_n));
`default_nettype wire

//--- dv/test_port5_pin_function_select.sv
/* Self-checking bench for p5fs_top: APB reads and writes, then pad and wakeup checks.
   Assumes the checker is bound to p5fs_top; inputs change by NBA at rising edges. */
`timescale 1ns/10ps
`default_nettype none
module test_port5_pin_function_select
  import p5fs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  p5fs_apb_req_t apbReq = '0;
  p5fs_apb_rsp_t apbRsp;
  p5fs_pin_drive_t gpioDrive = '0, padDrive;
  logic [6:2] padIn = 5'h00, gpioIn;
  logic [5:2] wakeupIn_n;
  logic adcExternalTriggerIn_n;
  logic [31:0] rd;
  logic [7:0] modes [7] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'hFF, 8'h00};
  int error_cnt = 0;
  int check_count = 0;
  always #50 clk = ~clk;
  p5fs_top DUT (.clk(clk), .rst_n(rst_n), .apbReq(apbReq), .apbRsp(apbRsp), .gpioDrive(gpioDrive), .padIn(padIn),
    .padDrive(padDrive), .gpioIn(gpioIn), .wakeupIn_n(wakeupIn_n), .adcExternalTriggerIn_n(adcExternalTriggerIn_n));
  task automatic conclude();
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Ready is sampled at the rising edge that ends the access; the request is released only after it
  task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd, input logic expErr);
    int n;
    apbReq <= '{1'b1, 1'b0, wr, addr, wd};
    @(posedge clk);
    apbReq.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (apbRsp.pready === 1'b1) break;
    end
    if (n == 20) begin
      error_cnt++;
      conclude();
    end
    rd = apbRsp.prdata;
    chk({31'h0, apbRsp.pslverr}, {31'h0, expErr});
    apbReq <= '0;
    @(posedge clk);
  endtask
  task automatic pins(input logic [6:2] m, input logic [6:2] p);
    padIn <= p;
    gpioDrive <= '{p, 5'h1F};
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(32'(padDrive.enable), 32'((5'h1F & ~m) | ({m[6], 4'h0} & ~p)));
    chk(32'(padDrive.level), 32'(p & ~m));
    chk(32'({adcExternalTriggerIn_n, wakeupIn_n}), 32'({p[5] | ~m[5], p[5:2] | ~m[5:2]}));
    chk(32'(gpioIn), 32'(p));
    @(posedge clk);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    xfer(1'b0, OFS_FUNCTION_SELECT, 32'h0, 1'b0);
    chk(rd, 32'h0);
    foreach (modes[i]) begin
      xfer(1'b1, OFS_FUNCTION_SELECT, {24'h0, modes[i]}, 1'b0);
      xfer(1'b0, OFS_FUNCTION_SELECT, 32'h0, 1'b0);
      chk(rd, {24'h0, modes[i] & 8'h7C});
      pins(modes[i][6:2], 5'h0A);
      pins(modes[i][6:2], 5'h15);
    end
    xfer(1'b1, OFS_PIN_LEVEL, 32'h7C, 1'b1);
    xfer(1'b1, 12'h008, 32'h7C, 1'b1);
    xfer(1'b0, OFS_FUNCTION_SELECT, 32'h0, 1'b0);
    chk(rd, 32'h0);
    xfer(1'b0, OFS_PIN_LEVEL, 32'h0, 1'b0);
    chk(rd, 32'h54);
    conclude();
  end
endmodule
`default_nettype wire
